// *** hw/rtcc_params.svh ***
// Register offsets, field positions, reset values and timing figures of the
// RTC control block. Included by every file that needs a number.
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH
`define RTCC_ADDR_CTRL 8'h0e
`define RTCC_ADDR_STAT 8'h0f
`define RTCC_ADDR_CHG 8'h10
`define RTCC_CTRL_RESET 8'h18
`define RTCC_STAT_RESET 8'h80
`define RTCC_CHG_RESET 8'h00
`define RTCC_CTRL_MASK 8'hbf
`define RTCC_BIT_OSC_DIS 7
`define RTCC_BIT_BACKUP_EN 5
`define RTCC_BIT_RATE_HI 4
`define RTCC_BIT_RATE_LO 3
`define RTCC_BIT_ALARM_SEL 2
`define RTCC_BIT_A2_EN 1
`define RTCC_BIT_A1_EN 0
`define RTCC_BIT_OSF 7
`define RTCC_BIT_A2F 1
`define RTCC_BIT_A1F 0
`define RTCC_KEY_HI 7
`define RTCC_KEY_LO 4
`define RTCC_DIODE_HI 3
`define RTCC_DIODE_LO 2
`define RTCC_RES_HI 1
`define RTCC_RES_LO 0
`define RTCC_CHARGE_KEY 4'ha
`define RTCC_DIODE_NONE 2'h1
`define RTCC_DIODE_ONE 2'h2
`define RTCC_RES_OFF 2'h0
`define RTCC_OSC_HZ 65536
`define RTCC_WAVE_1HZ 1
`define RTCC_WAVE_4K_HZ 4096
`define RTCC_WAVE_8K_HZ 8192
`define RTCC_WAVE_32K_HZ 32768
`define RTCC_DIV_W 16
`endif

// *** hw/rtcc_pkg.sv ***
// Types shared by the RTC control block and its square-wave generator.
// Assumes rtcc_params.svh is included by the users of these types.
package rtcc_pkg;
  typedef logic [1:0] rtcc_rate_t;
  typedef logic [1:0] rtcc_sel2_t;
  typedef logic [7:0] rtcc_byte_t;
endpackage

// *** hw/rtcc_top.sv ***
// Control, status and trickle-charger registers of a serial RTC, with the
// shared square-wave / alarm-interrupt open-drain pin.
// Assumes a bus engine on clk_i gives single-cycle register strobes and
// the alarm comparators pulse a match once per second on clk_i.
`timescale 1ns/1ns
`include "rtcc_params.svh"
// Overview of operation
// RULE1 - Oscillator runs while osc_disable is 0, halts at 1; reset clears it.
// RULE2 - On backup the pin is active only if backup_output_enable is 1.
// RULE3 - Rate bits pick 1Hz, 4.096kHz, 8.192kHz or 32.768kHz square wave.
// RULE4 - In alarm mode an enabled alarm match drives the pin, not the wave.
// RULE5 - alarm_output_select 0 outputs the square wave; it resets to 0.
// RULE6 - Alarm 2 flag interrupts only with its enable and alarm mode set.
// RULE7 - Alarm 1 flag interrupts only with its enable and alarm mode set.
// RULE8 - Interrupt pin is pulled low while either enabled alarm flag is set.
// RULE9 - osc_stopped_flag sets on the running-to-stopped edge of oscillator.
// RULE10 - osc_stopped_flag is 1 after reset and sets when osc_disable goes 1.
// RULE11 - osc_stopped_flag holds until written 0; writing 1 has no effect.
// RULE12 - alarm2_flag sets on alarm 2 match, clears on write 0 only.
// RULE13 - alarm1_flag sets on alarm 1 match, clears on write 0 only.
// RULE14 - Charger is enabled only when charge_key equals 1010.
// RULE15 - Charger configuration resets to all zeros, charger disabled.
// RULE16 - diode_select 01 no diode, 10 one diode, 00 and 11 disable.
// RULE17 - resistor_select 01 200 ohm, 10 2k, 11 4k, 00 disables.
// RULE18 - Software never picks 200 ohm while main supply exceeds 3.63V.
// RULE19 - Both alarms are compared once a second; a match sets its flag.
// RULE20 - An active alarm output stays active until its flag is cleared.
// RULE21 - Unused control and status bits read 0 and ignore writes.
// RULE22 - The square wave stops toggling while the oscillator is halted.
module rtcc_top #(
  parameter int OSC_HZ = `RTCC_OSC_HZ
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic osc_clk_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic alarm1_match_i,
  input wire logic alarm2_match_i,
  input wire logic osc_running_i,
  input wire logic on_backup_i,
  output logic wave_or_irq_pin_o,
  output logic wave_or_irq_pin_oe_o,
  output logic osc_enable_o,
  output logic charger_enable_o,
  output logic charger_diode_o,
  output logic [1:0] charger_res_sel_o
);
  // Reset images are typed constants so that single fields can be picked
  // out of them; a bare literal cannot be part-selected.
  localparam rtcc_pkg::rtcc_byte_t CTRL_RST = `RTCC_CTRL_RESET;
  localparam rtcc_pkg::rtcc_byte_t STAT_RST = `RTCC_STAT_RESET;
  localparam rtcc_pkg::rtcc_byte_t CHG_RST = `RTCC_CHG_RESET;

  // Register state.
  logic osc_disable;
  logic backup_output_enable;
  logic rate_select_high;
  logic rate_select_low;
  logic alarm_output_select;
  logic alarm2_irq_enable;
  logic alarm1_irq_enable;
  logic osc_stopped_flag;
  logic alarm2_flag;
  logic alarm1_flag;
  logic [3:0] charge_key;
  rtcc_pkg::rtcc_sel2_t diode_select;
  rtcc_pkg::rtcc_sel2_t resistor_select;

  // Synchronisers for pins and for the wave coming back from the
  // oscillator domain.
  logic running_meta;
  logic running_sync;
  logic running_prev;
  logic backup_meta;
  logic backup_sync;
  logic wave_meta;
  logic wave_sync;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_chg;
  logic osc_stop_edge;
  logic osc_disable_rise;
  logic irq_active;
  logic next_pin_oe;
  logic charge_ok;
  rtcc_pkg::rtcc_byte_t ctrl_value;
  rtcc_pkg::rtcc_byte_t stat_value;
  rtcc_pkg::rtcc_byte_t chg_value;
  rtcc_pkg::rtcc_byte_t next_rdata;

  rtcc_wave_if wave_if ();

  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  assign wr_ctrl = reg_wr_i && addr_hit(reg_addr_i, `RTCC_ADDR_CTRL);
  assign wr_stat = reg_wr_i && addr_hit(reg_addr_i, `RTCC_ADDR_STAT);
  assign wr_chg = reg_wr_i && addr_hit(reg_addr_i, `RTCC_ADDR_CHG);

  // Oscillator-side divider; its run input is osc_disable inverted.
  assign wave_if.run = ~osc_disable; // [RULE22]
  assign wave_if.rate = {rate_select_high, rate_select_low}; // [RULE3]

  rtcc_wave_gen #(
    .OSC_HZ(OSC_HZ)
  ) u_wave_gen (
    .osc_clk_i(osc_clk_i),
    .resetn_i(resetn_i),
    .wave_if(wave_if.gen)
  );

  // The running indication is sampled twice before the edge detector, so
  // a metastable sample never reaches the stop-flag logic.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      running_meta <= 1'b0;
      running_sync <= 1'b0;
      running_prev <= 1'b0;
    end else begin
      running_meta <= osc_running_i;
      running_sync <= running_meta;
      running_prev <= running_sync;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      backup_meta <= 1'b0;
      backup_sync <= 1'b0;
    end else begin
      backup_meta <= on_backup_i;
      backup_sync <= backup_meta;
    end
  end

  // The wave resets high, as the divider does, so no false low pulse
  // reaches the pin after reset.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wave_meta <= 1'b1;
      wave_sync <= 1'b1;
    end else begin
      wave_meta <= wave_if.wave;
      wave_sync <= wave_meta;
    end
  end

  // Control register; bit 6 is not stored. [RULE21]
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_disable <= CTRL_RST[`RTCC_BIT_OSC_DIS]; // [RULE1]
      backup_output_enable <= CTRL_RST[`RTCC_BIT_BACKUP_EN];
      rate_select_high <= CTRL_RST[`RTCC_BIT_RATE_HI];
      rate_select_low <= CTRL_RST[`RTCC_BIT_RATE_LO];
      alarm_output_select <= CTRL_RST[`RTCC_BIT_ALARM_SEL]; // [RULE5]
      alarm2_irq_enable <= CTRL_RST[`RTCC_BIT_A2_EN]; // [RULE6]
      alarm1_irq_enable <= CTRL_RST[`RTCC_BIT_A1_EN]; // [RULE7]
    end else if (wr_ctrl) begin
      osc_disable <= reg_wdata_i[`RTCC_BIT_OSC_DIS]; // [RULE1]
      backup_output_enable <= reg_wdata_i[`RTCC_BIT_BACKUP_EN];
      rate_select_high <= reg_wdata_i[`RTCC_BIT_RATE_HI];
      rate_select_low <= reg_wdata_i[`RTCC_BIT_RATE_LO];
      alarm_output_select <= reg_wdata_i[`RTCC_BIT_ALARM_SEL];
      alarm2_irq_enable <= reg_wdata_i[`RTCC_BIT_A2_EN];
      alarm1_irq_enable <= reg_wdata_i[`RTCC_BIT_A1_EN];
    end
  end

  assign osc_enable_o = ~osc_disable; // [RULE1]

  // Only the falling edge of the running indication counts, so a stopped
  // oscillator that is already flagged does not re-set after a clear.
  assign osc_stop_edge = running_prev && !running_sync; // [RULE9]
  assign osc_disable_rise = wr_ctrl && !osc_disable &&
                            reg_wdata_i[`RTCC_BIT_OSC_DIS]; // [RULE10]

  // Status flags: a set in the cycle of a clearing write wins.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_stopped_flag <= STAT_RST[`RTCC_BIT_OSF]; // [RULE10]
    end else if (osc_stop_edge || osc_disable_rise) begin
      osc_stopped_flag <= 1'b1; // [RULE9] [RULE10]
    end else if (wr_stat && !reg_wdata_i[`RTCC_BIT_OSF]) begin
      osc_stopped_flag <= 1'b0; // [RULE11]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm2_flag <= STAT_RST[`RTCC_BIT_A2F];
    end else if (alarm2_match_i) begin
      alarm2_flag <= 1'b1; // [RULE12] [RULE19]
    end else if (wr_stat && !reg_wdata_i[`RTCC_BIT_A2F]) begin
      alarm2_flag <= 1'b0; // [RULE12]
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm1_flag <= STAT_RST[`RTCC_BIT_A1F];
    end else if (alarm1_match_i) begin
      alarm1_flag <= 1'b1; // [RULE13] [RULE19]
    end else if (wr_stat && !reg_wdata_i[`RTCC_BIT_A1F]) begin
      alarm1_flag <= 1'b0; // [RULE13]
    end
  end

  // Trickle-charger configuration.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      charge_key <= CHG_RST[`RTCC_KEY_HI:`RTCC_KEY_LO]; // [RULE15]
      diode_select <= CHG_RST[`RTCC_DIODE_HI:`RTCC_DIODE_LO];
      resistor_select <= CHG_RST[`RTCC_RES_HI:`RTCC_RES_LO];
    end else if (wr_chg) begin
      charge_key <= reg_wdata_i[`RTCC_KEY_HI:`RTCC_KEY_LO];
      diode_select <= reg_wdata_i[`RTCC_DIODE_HI:`RTCC_DIODE_LO];
      resistor_select <= reg_wdata_i[`RTCC_RES_HI:`RTCC_RES_LO];
    end
  end

  // The key guards against a stray write turning the charger on.
  assign charge_ok = (charge_key == `RTCC_CHARGE_KEY) && // [RULE14]
                     (diode_select == `RTCC_DIODE_NONE ||
                      diode_select == `RTCC_DIODE_ONE) && // [RULE16]
                     (resistor_select != `RTCC_RES_OFF); // [RULE17]

  // The 200 ohm setting is passed through unchecked; supply voltage is not
  // visible here, so keeping it safe is left to software. [RULE18]
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      charger_enable_o <= 1'b0; // [RULE15]
      charger_diode_o <= 1'b0;
      charger_res_sel_o <= `RTCC_RES_OFF;
    end else begin
      charger_enable_o <= charge_ok; // [RULE14]
      charger_diode_o <= charge_ok &&
                         (diode_select == `RTCC_DIODE_ONE); // [RULE16]
      charger_res_sel_o <= charge_ok ? resistor_select
                                     : `RTCC_RES_OFF; // [RULE17]
    end
  end

  // Interrupt level follows the flags, so it holds until software clears
  // them. [RULE20]
  assign irq_active = alarm_output_select &&
                      ((alarm2_flag && alarm2_irq_enable) || // [RULE6]
                       (alarm1_flag && alarm1_irq_enable)); // [RULE7] [RULE8]

  always_comb begin
    if (backup_sync && !backup_output_enable) begin
      next_pin_oe = 1'b0; // [RULE2]
    end else if (alarm_output_select) begin
      next_pin_oe = irq_active; // [RULE4] [RULE8]
    end else begin
      next_pin_oe = !wave_sync; // [RULE5]
    end
  end

  // The pin is open drain: it only ever pulls low.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wave_or_irq_pin_oe_o <= 1'b0;
    end else begin
      wave_or_irq_pin_oe_o <= next_pin_oe;
    end
  end

  assign wave_or_irq_pin_o = 1'b0;

  // Read-back; unused bits are forced to zero. [RULE21]
  assign ctrl_value = {osc_disable, 1'b0, backup_output_enable,
                       rate_select_high, rate_select_low,
                       alarm_output_select, alarm2_irq_enable,
                       alarm1_irq_enable} & `RTCC_CTRL_MASK;
  assign stat_value = {osc_stopped_flag, 5'h00, alarm2_flag, alarm1_flag};
  assign chg_value = {charge_key, diode_select, resistor_select};

  always_comb begin
    next_rdata = 8'h00;
    if (addr_hit(reg_addr_i, `RTCC_ADDR_CTRL)) begin
      next_rdata = ctrl_value;
    end else if (addr_hit(reg_addr_i, `RTCC_ADDR_STAT)) begin
      next_rdata = stat_value;
    end else if (addr_hit(reg_addr_i, `RTCC_ADDR_CHG)) begin
      next_rdata = chg_value;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule // rtcc_top

// *** hw/rtcc_wave_gen.sv ***
// Square-wave divider clocked by the oscillator.
// Assumes run and rate are quasi-static levels from the clk_i domain.
`timescale 1ns/1ns
`include "rtcc_params.svh"
module rtcc_wave_gen #(
  parameter int OSC_HZ = `RTCC_OSC_HZ
) (
  input wire logic osc_clk_i,
  input wire logic resetn_i,
  rtcc_wave_if.gen wave_if
);
  localparam logic [`RTCC_DIV_W-1:0] HALF_1HZ =
    `RTCC_DIV_W'(OSC_HZ / (2 * `RTCC_WAVE_1HZ) - 1);
  localparam logic [`RTCC_DIV_W-1:0] HALF_4K =
    `RTCC_DIV_W'(OSC_HZ / (2 * `RTCC_WAVE_4K_HZ) - 1);
  localparam logic [`RTCC_DIV_W-1:0] HALF_8K =
    `RTCC_DIV_W'(OSC_HZ / (2 * `RTCC_WAVE_8K_HZ) - 1);
  localparam logic [`RTCC_DIV_W-1:0] HALF_32K =
    `RTCC_DIV_W'(OSC_HZ / (2 * `RTCC_WAVE_32K_HZ) - 1);

  logic run_meta;
  logic run_sync;
  rtcc_pkg::rtcc_rate_t rate_meta;
  rtcc_pkg::rtcc_rate_t rate_sync;
  logic [`RTCC_DIV_W-1:0] count;
  logic [`RTCC_DIV_W-1:0] half_limit;
  logic wave;

  // Rate bits are synchronised one by one; a rate change may give one odd
  // half period, which is harmless for a square wave.
  always_ff @(posedge osc_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      rate_meta <= 2'h0;
      rate_sync <= 2'h0;
    end else begin
      run_meta <= wave_if.run;
      run_sync <= run_meta;
      rate_meta <= wave_if.rate;
      rate_sync <= rate_meta;
    end
  end

  always_comb begin
    unique case (rate_sync)
      2'h0: half_limit = HALF_1HZ;
      2'h1: half_limit = HALF_4K;
      2'h2: half_limit = HALF_8K;
      2'h3: half_limit = HALF_32K;
    endcase
  end

  // The divider freezes while the oscillator is halted. [RULE22]
  always_ff @(posedge osc_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
      wave <= 1'b1;
    end else if (run_sync) begin
      if (count >= half_limit) begin
        count <= '0;
        wave <= ~wave; // [RULE3]
      end else begin
        count <= count + `RTCC_DIV_W'(1);
      end
    end
  end

  assign wave_if.wave = wave;
endmodule // rtcc_wave_gen

// *** hw/rtcc_wave_if.sv ***
// Carrier between the register side and the oscillator-side wave generator.
// The ctl end runs on clk_i, the gen end on the oscillator clock.
`timescale 1ns/1ns
interface rtcc_wave_if;
  logic run;
  rtcc_pkg::rtcc_rate_t rate;
  logic wave;
  modport ctl (output run, output rate, input wave);
  modport gen (input run, input rate, output wave);
endinterface // rtcc_wave_if

// *** verification/rtcc_chk.sv ***
// Concurrent checks on the ports of rtcc_top, bound into it below.
// Assumes one clk_i domain and one-cycle register strobes.
`timescale 1ns/1ns
`include "rtcc_params.svh"
module rtcc_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic alarm1_match_i,
  input wire logic on_backup_i,
  input wire logic wave_or_irq_pin_oe_o,
  input wire logic osc_enable_o,
  input wire logic charger_enable_o,
  input wire logic [1:0] charger_res_sel_o
);
  logic [7:0] ctrl;
  logic wr_ctrl;
  logic wr_chg;
  assign wr_ctrl = reg_wr_i && reg_addr_i == `RTCC_ADDR_CTRL;
  assign wr_chg = reg_wr_i && reg_addr_i == `RTCC_ADDR_CHG;
  // Shadow of the control register, so the pin checks know the mode.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= `RTCC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata_i & `RTCC_CTRL_MASK;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Two cycles allow for an extra output register after the write.
  a_osc_follows_bit: assert property (
    wr_ctrl |-> ##2 osc_enable_o == !ctrl[7])
    else $error("osc enable does not follow control bit");
  a_key_gates_charger: assert property (
    wr_chg && reg_wdata_i[7:4] != 4'ha |-> ##2 !charger_enable_o)
    else $error("charger on without key");
  a_diode_gates_charger: assert property (
    wr_chg && reg_wdata_i[3] == reg_wdata_i[2] |-> ##2 !charger_enable_o)
    else $error("charger on with invalid diode field");
  a_res_off_gates: assert property (
    wr_chg && reg_wdata_i[1:0] == 2'h0 |-> ##2
      charger_res_sel_o == 2'h0 && !charger_enable_o)
    else $error("charger on with resistor off");
  a_irq_raise: assert property (
    alarm1_match_i && ctrl[2] && ctrl[0] && !on_backup_i
      |-> ##2 wave_or_irq_pin_oe_o)
    else $error("enabled alarm did not pull the pin");
  a_irq_masked: assert property (
    ctrl[2] && ctrl[1:0] == 2'h0 && $past(ctrl, 2) == ctrl
      |-> !wave_or_irq_pin_oe_o)
    else $error("pin pulled with both alarm enables off");
  a_irq_holds: assert property (
    wave_or_irq_pin_oe_o && ctrl[2] && $past(ctrl) == ctrl && !on_backup_i
      && !reg_wr_i && !$past(reg_wr_i) |=> wave_or_irq_pin_oe_o)
    else $error("alarm output released without a flag clear");
  a_ctrl_readback: assert property (
    reg_rd_i && !reg_wr_i && reg_addr_i == `RTCC_ADDR_CTRL
      |=> reg_rdata_o == ctrl)
    else $error("control read differs from written value");
  a_status_zeros: assert property (
    reg_rd_i && reg_addr_i == `RTCC_ADDR_STAT |=> reg_rdata_o[6:2] == 5'h00)
    else $error("unused status bits read nonzero");
  c_alarm_mode: cover property (alarm1_match_i && ctrl[2] && ctrl[0]);
  c_charger_on: cover property (charger_enable_o);
  c_osc_halt: cover property (!osc_enable_o);
endmodule // rtcc_chk

bind rtcc_top rtcc_chk chk_u (
  .clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .alarm1_match_i, .on_backup_i, .wave_or_irq_pin_oe_o,
  .osc_enable_o, .charger_enable_o, .charger_res_sel_o);

// *** verification/rtcc_master.sv ***
// Register-port master standing in for the two-wire bus engine.
// Assumes the block takes one strobe per clk_i edge, reads a cycle later.
`timescale 1ns/1ns
module rtcc_master (
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  // The bench supply is taken as under 3.63V, so 200 ohm is allowed.
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // Read data holds until the next read, so sampling at the edge is safe.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule // rtcc_master

// *** verification/tb.sv ***
// Self-checking bench for rtcc_top driven through its register port.
// Assumes the oscillator clock runs free at 80 ns, eight clk_i cycles.
`timescale 1ns/1ns
`include "rtcc_params.svh"
module tb;
  logic clk_i, osc_clk, resetn, a1, a2, run, bak, wr, rd, pin, oe;
  logic osc_en, chg_en, chg_d;
  logic [1:0] chg_r;
  logic [7:0] addr, wdata, rdata, rv;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  int hz[4] = '{`RTCC_WAVE_1HZ, `RTCC_WAVE_4K_HZ, `RTCC_WAVE_8K_HZ,
    `RTCC_WAVE_32K_HZ};
  logic [11:0] tab[10] = '{12'h9a5, 12'hda9, 12'haa6, 12'hfab, 12'hba7,
    12'heaa, 12'h055, 12'h0a1, 12'h0ad, 12'h0a4};
  rtcc_master m_u (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .rdata_i(rdata));
  rtcc_top dut_u (.clk_i(clk_i), .resetn_i(resetn), .osc_clk_i(osc_clk),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .alarm1_match_i(a1), .alarm2_match_i(a2),
    .osc_running_i(run), .on_backup_i(bak), .wave_or_irq_pin_o(pin),
    .wave_or_irq_pin_oe_o(oe), .osc_enable_o(osc_en),
    .charger_enable_o(chg_en), .charger_diode_o(chg_d),
    .charger_res_sel_o(chg_r));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #40 osc_clk = ~osc_clk;
  end
  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a,
                        input logic [7:0] e);
    m_u.read_reg(a, rv);
    check(w, rv, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic pulse(input logic [1:0] m);
    a1 <= m[0];
    a2 <= m[1];
    @(posedge clk_i);
    a1 <= 1'b0;
    a2 <= 1'b0;
    @(posedge clk_i);
  endtask
  // Sampled on the falling edge, away from the edge that updates the pin.
  task automatic until_oe(input logic v, inout int k);
    while (oe !== v && k < 999) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic period(input int e);
    n = 0;
    until_oe(1'b0, n);
    until_oe(1'b1, n);
    n = 0;
    until_oe(1'b0, n);
    until_oe(1'b1, n);
    check("wave period", 8'(n > e - 2 && n < e + 2), 8'h01);
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    resetn = 1'b0;
    a1 = 1'b0;
    a2 = 1'b0;
    run = 1'b1;
    bak = 1'b0;
    tick(16);
    resetn <= 1'b1;
    tick(1);
    rd_chk("ctrl reset", 8'h0e, 8'h18);
    rd_chk("status reset", 8'h0f, 8'h80);
    rd_chk("charger reset", 8'h10, 8'h00);
    rd_chk("unmapped", 8'h11, 8'h00);
    check("osc enable", {7'h00, osc_en}, 8'h01);
    check("pin level", {7'h00, pin}, 8'h00);
    m_u.write_reg(8'h0e, 8'h40);
    rd_chk("ctrl unused", 8'h0e, 8'h00);
    m_u.write_reg(8'h0f, 8'hff);
    rd_chk("status ones", 8'h0f, 8'h80);
    m_u.write_reg(8'h0f, 8'h00);
    rd_chk("osf clear", 8'h0f, 8'h00);
    run <= 1'b0;
    tick(6);
    rd_chk("osf edge", 8'h0f, 8'h80);
    run <= 1'b1;
    m_u.write_reg(8'h0f, 8'h00);
    $display("test registers done");
    m_u.write_reg(8'h0e, 8'h04);
    pulse(2'b11);
    tick(3);
    check("masked irq", {7'h00, oe}, 8'h00);
    rd_chk("both flags", 8'h0f, 8'h03);
    m_u.write_reg(8'h0f, 8'h02);
    rd_chk("a1 clear", 8'h0f, 8'h02);
    m_u.write_reg(8'h0e, 8'h05);
    tick(3);
    check("a2 ignored", {7'h00, oe}, 8'h00);
    pulse(2'b01);
    tick(10);
    check("a1 irq", {7'h00, oe}, 8'h01);
    m_u.write_reg(8'h0f, 8'h00);
    tick(3);
    check("irq release", {7'h00, oe}, 8'h00);
    m_u.write_reg(8'h0e, 8'h06);
    pulse(2'b10);
    tick(3);
    check("a2 irq", {7'h00, oe}, 8'h01);
    bak <= 1'b1;
    tick(6);
    check("backup off", {7'h00, oe}, 8'h00);
    m_u.write_reg(8'h0e, 8'h26);
    tick(3);
    check("backup on", {7'h00, oe}, 8'h01);
    bak <= 1'b0;
    m_u.write_reg(8'h0f, 8'h00);
    $display("test alarms done");
    // The 1 Hz rate is too slow for this run and is left out.
    for (int i = 1; i < 4; i++) begin
      m_u.write_reg(8'h0e, 8'(i << 3));
      tick(40);
      period(`RTCC_OSC_HZ / hz[i] * 8);
    end
    m_u.write_reg(8'h0e, 8'h98);
    tick(30);
    @(negedge clk_i);
    rv[0] = oe;
    n = 900;
    until_oe(~rv[0], n);
    check("wave halted", 8'(n == 999), 8'h01);
    check("osc halted", {7'h00, osc_en}, 8'h00);
    @(posedge clk_i);
    rd_chk("osf disable", 8'h0f, 8'h80);
    m_u.write_reg(8'h0e, 8'h18);
    $display("test wave done");
    for (int i = 0; i < 10; i++) begin
      m_u.write_reg(8'h10, tab[i][7:0]);
      tick(3);
      rv = {4'h0, chg_en, chg_d, chg_r};
      check("chg", rv, {4'h0, tab[i][11:8]});
      rd_chk("charger value", 8'h10, tab[i][7:0]);
    end
    $display("test charger done");
    complete_run();
  end
endmodule // tb
